/* File: logic/grsl_top.sv */
// module: bus remote/local control, command parsing and status system
// Behaviour
// [RL1] local key returns device to local
// [RL2] remote lights indicator, blocks keypad
// [RL3] remote enable from controller enters remote
// [RL4] interface clear aborts any transfer
// [RL5] service request line asserted for service
// [RL6] attention bytes are interface commands
// [RL7] lockout disables panel including local key
// [RL8] device clear idles the bus interface
// [RL9] addressed commands need own listen address
// [RL10] selective clear acts like device clear
// [RL11] go-to-local while addressed leaves remote
// [RL12] trigger while addressed starts triggered operation
// [RL13] serial poll sends status byte when talking
// [RL14] star means common, question mark means query
// [RL15] controller chains commands, at most 255 chars
// [RL16] controller ends each message with terminator
// [RL17] only latest query answered, only when talking
// [RL18] condition registers follow live status
// [RL19] event bits latch until read or cleared
// [RL20] enabled event bits form set summary
// [RL21] status byte mirrors summaries, not latched
// [RL22] service bit drives request line, reported
// [RL23] service bit from summaries and request enable
// [RL24] registers read as binary-weighted sum
// [RL25] enables cleared by zero, reset clears all
// [RL26] summary is OR of event AND enable
`timescale 1ns/1ps
module grsl_top #(
  parameter int NSETS = 4,
  parameter int KEY_W = 8
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [7:0]         awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [7:0]         araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  input  wire logic               ren_n,
  input  wire logic               ifc_n,
  input  wire logic               rx_valid,
  input  wire logic [7:0]         rx_data,
  input  wire logic               rx_atn_n,
  input  wire logic               rx_eoi_n,
  output logic                    rx_ready,
  output logic                    tx_valid,
  output logic [7:0]              tx_data,
  output logic                    tx_eoi,
  input  wire logic               tx_ready,
  output logic                    srq_out,
  output logic                    srq_oe_n,
  input  wire logic               local_key,
  input  wire logic               remote_key,
  input  wire logic [KEY_W-1:0]   keypad_in,
  output logic [KEY_W-1:0]        keypad_out,
  output logic                    remote_led,
  output logic                    trigger,
  input  wire logic [NSETS*8-1:0] cond,
  input  wire logic [7:0]         std_evt
);

  // word-aligned address of a byte address
  function automatic logic [7:0] word_of(input logic [7:0] a);
    return {a[7:2], 2'b00};
  endfunction

  // address of one field of status set k
  function automatic logic [7:0] set_addr(input int k, input logic [7:0] f);
    return grsl_pkg::OFF_SET_BASE + 8'(k) * grsl_pkg::SET_STRIDE + f;
  endfunction

  grsl_pkg::grsl_rl_t rl_state;
  logic [4:0]  my_addr;
  logic [7:0]  sre, esr, ese, rsp_byte, rxd_byte;
  logic [7:0]  evt [NSETS];
  logic [7:0]  ena [NSETS];
  logic [NSETS*8-1:0] cond_q;
  logic        aw_full, w_full, rsp_last, rsp_pend, rxd_full;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        lad, tad, spm, sp_sent, ren_q;
  logic        unit_start, unit_common, unit_query, seen_space;
  logic [2:0]  rxd_flags;
  logic        wr_do, wr_hit, rd_take, rd_hit, dt, ct, abort, dev_clr;
  logic        next_aw_full, next_w_full, next_rvalid, next_rxd_full;
  logic        next_common, next_query, is_term, q_end, cls_wr;
  logic        sp_load, rsp_load, remote, esb, mss, esr_clr;
  logic [7:0]  stb, b;
  logic [NSETS-1:0] sums;
  logic [31:0] rd_mux;

  // bus handshakes and byte classification
  assign wr_do    = aw_full & w_full & ~bvalid;
  assign rd_take  = arvalid & arready;
  assign next_aw_full = (awvalid & awready) | (aw_full & ~wr_do);
  assign next_w_full  = (wvalid & wready) | (w_full & ~wr_do);
  assign next_rvalid  = rd_take | (rvalid & ~rready);
  assign b        = rx_data;
  assign ct       = rx_valid & ~rx_atn_n;             // [RL6]
  assign dt       = rx_valid & rx_ready & rx_atn_n;   // [RL6]
  assign abort    = ~ifc_n;
  assign dev_clr  = ct & ((b == grsl_pkg::CMD_DCL) |
                    ((b == grsl_pkg::CMD_SDC) & lad)); // [RL8] [RL10]
  assign remote   = (rl_state == grsl_pkg::GRSL_REMOTE) |
                    (rl_state == grsl_pkg::GRSL_REM_LOCK);
  assign cls_wr   = wr_do & (word_of(aw_addr_q) == grsl_pkg::OFF_CLS) &
                    w_strb_q[0] & w_data_q[0];
  assign esr_clr  = cls_wr |
                    (rd_take & (word_of(araddr) == grsl_pkg::OFF_ESR));

  // message framing: common/query flags of the current unit
  assign is_term     = (b == grsl_pkg::CH_LF) | (b == grsl_pkg::CH_SEMI) |
                       ~rx_eoi_n;
  assign next_common = unit_start ? (b == grsl_pkg::CH_STAR)
                                  : unit_common;      // [RL14]
  assign next_query  = unit_query |
                       ((b == grsl_pkg::CH_QMARK) & ~seen_space); // [RL14]
  assign q_end       = dt & is_term & next_query;
  assign next_rxd_full = ~dev_clr & (dt | (rxd_full & ~(rd_take &
                         (word_of(araddr) == grsl_pkg::OFF_RXD))));

  // summaries, status byte and service request
  always_comb begin
    for (int k = 0; k < NSETS; k++) begin
      sums[k] = |(evt[k] & ena[k]);                   // [RL20] [RL26]
    end
    esb = |(esr & ese);                               // [RL26]
    stb = 8'h00;
    stb[NSETS-1:0] = sums;                            // [RL21]
    stb[grsl_pkg::MAV_BIT] = rsp_pend;
    stb[grsl_pkg::ESB_BIT] = esb;
    mss = |(stb & sre & ~(8'h01 << grsl_pkg::MSS_BIT)); // [RL23]
    stb[grsl_pkg::MSS_BIT] = mss;                     // [RL22]
  end

  // transmit loads: serial poll first, then a pending response
  assign sp_load  = spm & tad & ~tx_valid & ~sp_sent & ~abort; // [RL13]
  assign rsp_load = ~spm & tad & ~tx_valid & rsp_pend & ~abort &
                    ~dev_clr;                         // [RL17]

  // register read multiplexer
  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (word_of(araddr))
      grsl_pkg::OFF_CTRL: rd_mux = {27'h0, my_addr};
      grsl_pkg::OFF_STB:  rd_mux = {24'h0, stb};      // [RL21] [RL24]
      grsl_pkg::OFF_SRE:  rd_mux = {24'h0, sre};
      grsl_pkg::OFF_ESR:  rd_mux = {24'h0, esr};
      grsl_pkg::OFF_ESE:  rd_mux = {24'h0, ese};
      grsl_pkg::OFF_RSP:  rd_mux = {23'h0, rsp_pend, rsp_byte};
      grsl_pkg::OFF_RXD:  rd_mux = {21'h0, rxd_flags, rxd_byte} &
                                   {23'h0, rxd_full, 8'hff};
      grsl_pkg::OFF_CLS:  rd_mux = 32'h0;
      default:            rd_hit = 1'b0;
    endcase
    for (int k = 0; k < NSETS; k++) begin
      if (word_of(araddr) == set_addr(k, grsl_pkg::SET_COND)) begin
        rd_mux = {24'h0, cond[k*8 +: 8]};             // [RL18]
        rd_hit = 1'b1;
      end
      if (word_of(araddr) == set_addr(k, grsl_pkg::SET_EVT)) begin
        rd_mux = {24'h0, evt[k]};                     // [RL24]
        rd_hit = 1'b1;
      end
      if (word_of(araddr) == set_addr(k, grsl_pkg::SET_ENA)) begin
        rd_mux = {24'h0, ena[k]};
        rd_hit = 1'b1;
      end
    end
  end

  // write address decode
  always_comb begin
    wr_hit = 1'b0;
    case (word_of(aw_addr_q))
      grsl_pkg::OFF_CTRL, grsl_pkg::OFF_SRE, grsl_pkg::OFF_ESE,
      grsl_pkg::OFF_RSP, grsl_pkg::OFF_CLS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
    for (int k = 0; k < NSETS; k++) begin
      if (word_of(aw_addr_q) == set_addr(k, grsl_pkg::SET_ENA)) begin
        wr_hit = 1'b1;
      end
    end
  end

  // control bus write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full   <= 1'b0;
      w_full    <= 1'b0;
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= grsl_pkg::RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
    end else begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      awready <= ~next_aw_full;
      wready  <= ~next_w_full;
      if (awvalid & awready) begin
        aw_addr_q <= awaddr;
      end
      if (wvalid & wready) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_do) begin
        bvalid <= 1'b1;
        bresp  <= wr_hit ? grsl_pkg::RESP_OKAY : grsl_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // control bus read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= grsl_pkg::RESP_OKAY;
    end else begin
      rvalid  <= next_rvalid;
      arready <= ~next_rvalid;
      if (rd_take) begin
        rdata <= rd_mux;
        rresp <= rd_hit ? grsl_pkg::RESP_OKAY : grsl_pkg::RESP_SLVERR;
      end
    end
  end

  // software-written registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      my_addr <= grsl_pkg::ADDR_RST;
      sre     <= 8'h00;                               // [RL25]
      ese     <= 8'h00;                               // [RL25]
      for (int k = 0; k < NSETS; k++) begin
        ena[k] <= 8'h00;                              // [RL25]
      end
    end else if (wr_do & w_strb_q[0]) begin
      case (word_of(aw_addr_q))
        grsl_pkg::OFF_CTRL: my_addr <= w_data_q[4:0];
        grsl_pkg::OFF_SRE:  sre     <= w_data_q[7:0]; // [RL23] [RL25]
        grsl_pkg::OFF_ESE:  ese     <= w_data_q[7:0]; // [RL20] [RL25]
        default: ;
      endcase
      for (int k = 0; k < NSETS; k++) begin
        if (word_of(aw_addr_q) == set_addr(k, grsl_pkg::SET_ENA)) begin
          ena[k] <= w_data_q[7:0];                    // [RL20] [RL25]
        end
      end
    end
  end

  // event registers: set wins over a read or clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      esr    <= 8'h00;                                // [RL25]
      cond_q <= '0;
      for (int k = 0; k < NSETS; k++) begin
        evt[k] <= 8'h00;                              // [RL25]
      end
    end else begin
      cond_q <= cond;
      esr    <= (esr & ~{8{esr_clr}}) | std_evt;      // [RL19]
      for (int k = 0; k < NSETS; k++) begin
        evt[k] <= (evt[k] & ~{8{cls_wr | (rd_take & (word_of(araddr) ==
                  set_addr(k, grsl_pkg::SET_EVT)))}}) |
                  (cond[k*8 +: 8] & ~cond_q[k*8 +: 8]); // [RL19]
      end
    end
  end

  // listen/talk addressing and serial poll mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lad <= 1'b0;
      tad <= 1'b0;
      spm <= 1'b0;
    end else if (abort) begin
      lad <= 1'b0;                                    // [RL4]
      tad <= 1'b0;
      spm <= 1'b0;
    end else if (ct) begin
      if (b == grsl_pkg::CMD_UNL) begin
        lad <= 1'b0;
      end else if (b == grsl_pkg::CMD_UNT) begin
        tad <= 1'b0;
      end else if (b == {grsl_pkg::GRP_LISTEN, my_addr}) begin
        lad <= 1'b1;                                  // [RL9]
        tad <= 1'b0;
      end else if (b[7:5] == grsl_pkg::GRP_TALK) begin
        tad <= (b[4:0] == my_addr);
        if (b[4:0] == my_addr) begin
          lad <= 1'b0;
        end
      end else if (b == grsl_pkg::CMD_SPE) begin
        spm <= 1'b1;                                  // [RL13]
      end else if (b == grsl_pkg::CMD_SPD) begin
        spm <= 1'b0;                                  // [RL13]
      end
    end
  end

  // remote/local state with lockout
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rl_state <= grsl_pkg::GRSL_LOCAL;
      ren_q    <= 1'b0;
    end else begin
      ren_q <= ~ren_n;
      case (rl_state)
        grsl_pkg::GRSL_LOCAL, grsl_pkg::GRSL_REMOTE,
        grsl_pkg::GRSL_REM_LOCK, grsl_pkg::GRSL_LOC_LOCK: begin
          if (ren_n & ren_q) begin
            rl_state <= grsl_pkg::GRSL_LOCAL;         // lockout released
          end else if (~ren_n & ~ren_q) begin
            rl_state <= rl_state[1] ? grsl_pkg::GRSL_REM_LOCK
                                    : grsl_pkg::GRSL_REMOTE; // [RL3]
          end else if (ct & (b == grsl_pkg::CMD_LLO)) begin
            rl_state <= remote ? grsl_pkg::GRSL_REM_LOCK
                               : grsl_pkg::GRSL_LOC_LOCK; // [RL7]
          end else if (ct & (b == grsl_pkg::CMD_GTL) & lad) begin
            rl_state <= rl_state[1] ? grsl_pkg::GRSL_LOC_LOCK
                                    : grsl_pkg::GRSL_LOCAL; // [RL11]
          end else if (local_key &
                       (rl_state == grsl_pkg::GRSL_REMOTE)) begin
            rl_state <= grsl_pkg::GRSL_LOCAL;         // [RL1] [RL7]
          end else if (remote_key & ~remote) begin
            rl_state <= rl_state[1] ? grsl_pkg::GRSL_REM_LOCK
                                    : grsl_pkg::GRSL_REMOTE;
          end
        end
        default: rl_state <= grsl_pkg::GRSL_LOCAL;
      endcase
    end
  end

  // front panel outputs, trigger and service request pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      keypad_out <= '0;
      remote_led <= 1'b0;
      trigger    <= 1'b0;
      srq_out    <= 1'b0;
      srq_oe_n   <= 1'b1;
    end else begin
      keypad_out <= remote ? '0 : keypad_in;          // [RL2]
      remote_led <= remote;                           // [RL2]
      trigger    <= ct & (b == grsl_pkg::CMD_GET) & lad; // [RL9] [RL12]
      srq_out    <= 1'b0;
      srq_oe_n   <= ~mss;                             // [RL5] [RL22]
    end
  end

  // received message bytes and framing state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_full    <= 1'b0;
      rx_ready    <= 1'b1;
      rxd_byte    <= 8'h00;
      rxd_flags   <= 3'h0;
      unit_start  <= 1'b1;
      unit_common <= 1'b0;
      unit_query  <= 1'b0;
      seen_space  <= 1'b0;
    end else begin
      rxd_full <= next_rxd_full;
      rx_ready <= ~next_rxd_full;
      if (dev_clr | abort) begin
        unit_start <= 1'b1;                           // [RL8]
        unit_query <= 1'b0;
        seen_space <= 1'b0;
      end else if (dt) begin
        rxd_byte    <= b;
        rxd_flags   <= {is_term, next_query, next_common};
        unit_start  <= is_term;
        unit_common <= is_term ? 1'b0 : next_common;
        unit_query  <= is_term ? 1'b0 : next_query;
        seen_space  <= ~is_term & (seen_space | (b == grsl_pkg::CH_SPACE));
      end
    end
  end

  // response holding and talker output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_pend <= 1'b0;
      rsp_byte <= 8'h00;
      rsp_last <= 1'b0;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_eoi   <= 1'b0;
      sp_sent  <= 1'b0;
    end else begin
      if (dev_clr | q_end) begin
        rsp_pend <= 1'b0;                             // [RL8] [RL17]
      end else if (wr_do & w_strb_q[0] &
                   (word_of(aw_addr_q) == grsl_pkg::OFF_RSP)) begin
        rsp_pend <= 1'b1;
        rsp_byte <= w_data_q[7:0];
        rsp_last <= w_data_q[grsl_pkg::RSP_LAST_BIT];
      end else if (rsp_load) begin
        rsp_pend <= 1'b0;
      end
      if (ct & ((b == grsl_pkg::CMD_SPE) | (b == grsl_pkg::CMD_SPD))) begin
        sp_sent <= 1'b0;
      end else if (sp_load) begin
        sp_sent <= 1'b1;
      end
      if (abort | dev_clr) begin
        tx_valid <= 1'b0;                             // [RL4] [RL8]
      end else if (sp_load) begin
        tx_valid <= 1'b1;
        tx_data  <= stb;                              // [RL13]
        tx_eoi   <= 1'b0;
      end else if (rsp_load) begin
        tx_valid <= 1'b1;
        tx_data  <= rsp_byte;                         // [RL17]
        tx_eoi   <= rsp_last;
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
      end
    end
  end

  default clocking grsl_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_get_listen;
    ct && (b == grsl_pkg::CMD_GET) && lad;
  endsequence
  sequence s_poll_ready;
    spm && tad && !tx_valid && !sp_sent && ifc_n;
  endsequence

  a_ifc_abort: assert property (!ifc_n |=> !tx_valid && !lad && !tad) // [RL4]
    else $error("interface clear left a transfer or address active");
  a_lock_local: assert property (rl_state == grsl_pkg::GRSL_REM_LOCK &&
    local_key && !(ren_n && ren_q) |=> remote) // [RL7]
    else $error("local key escaped lockout");
  a_keypad_block: assert property ($past(remote) |-> keypad_out == '0) // [RL2]
    else $error("keypad passed while remote");
  a_ren_remote: assert property (!ren_n && !ren_q |=> remote) // [RL3]
    else $error("remote enable did not enter remote");
  a_get_trigger: assert property (s_get_listen |=> trigger) // [RL12]
    else $error("addressed trigger not issued");
  a_unaddr_ignore: assert property (ct && !lad |=> !trigger) // [RL9]
    else $error("trigger issued while not addressed");
  a_srq_follow: assert property (mss |=> !srq_oe_n) // [RL5]
    else $error("service request line not driven");
  a_poll_byte: assert property (s_poll_ready ##1 tx_valid |->
    tx_data == $past(stb)) // [RL13]
    else $error("serial poll byte is not the status byte");
  a_query_drop: assert property (q_end |=> !rsp_pend) // [RL17]
    else $error("stale response kept after new query");
  a_esr_hold: assert property (!esr_clr |=> // [RL19]
    (esr & $past(esr)) == $past(esr))
    else $error("event bit lost without clear");
  a_mss_gate: assert property (sre == 8'h00 |-> !mss) // [RL23]
    else $error("service bit set with no request enable");
endmodule

/* File: logic/grsl_pkg.sv */
// package: constants for the bus remote/local and status logic
package grsl_pkg;
  // register byte offsets on the control bus
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STB      = 8'h04;
  localparam logic [7:0] OFF_SRE      = 8'h08;
  localparam logic [7:0] OFF_ESR      = 8'h0c;
  localparam logic [7:0] OFF_ESE      = 8'h10;
  localparam logic [7:0] OFF_RSP      = 8'h14;
  localparam logic [7:0] OFF_RXD      = 8'h18;
  localparam logic [7:0] OFF_CLS      = 8'h1c;
  localparam logic [7:0] OFF_SET_BASE = 8'h20;
  localparam logic [7:0] SET_STRIDE   = 8'h10;
  localparam logic [7:0] SET_COND     = 8'h00;
  localparam logic [7:0] SET_EVT      = 8'h04;
  localparam logic [7:0] SET_ENA      = 8'h08;
  // reset values and field positions
  localparam logic [4:0] ADDR_RST     = 5'h0c;
  localparam int         MAV_BIT      = 4;
  localparam int         ESB_BIT      = 5;
  localparam int         MSS_BIT      = 6;
  localparam int         RSP_LAST_BIT = 8;
  localparam int         RXD_VAL_BIT  = 8;
  // interface command bytes sent under attention
  localparam logic [7:0] CMD_GTL      = 8'h01;
  localparam logic [7:0] CMD_SDC      = 8'h04;
  localparam logic [7:0] CMD_GET      = 8'h08;
  localparam logic [7:0] CMD_LLO      = 8'h11;
  localparam logic [7:0] CMD_DCL      = 8'h14;
  localparam logic [7:0] CMD_SPE      = 8'h18;
  localparam logic [7:0] CMD_SPD      = 8'h19;
  localparam logic [7:0] CMD_UNL      = 8'h3f;
  localparam logic [7:0] CMD_UNT      = 8'h5f;
  localparam logic [2:0] GRP_LISTEN   = 3'h1;
  localparam logic [2:0] GRP_TALK     = 3'h2;
  // message characters
  localparam logic [7:0] CH_STAR      = 8'h2a;
  localparam logic [7:0] CH_QMARK     = 8'h3f;
  localparam logic [7:0] CH_SEMI      = 8'h3b;
  localparam logic [7:0] CH_SPACE     = 8'h20;
  localparam logic [7:0] CH_LF        = 8'h0a;
  // bus responses
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  // remote/local states
  typedef enum logic [1:0] {
    GRSL_LOCAL     = 2'b00,
    GRSL_REMOTE    = 2'b01,
    GRSL_REM_LOCK  = 2'b10,
    GRSL_LOC_LOCK  = 2'b11
  } grsl_rl_t;
endpackage

/* File: dv/grsl_ctl_model.sv */
// bus controller model: remote/clear lines, bytes to the device, listener
`timescale 1ns/1ps
module grsl_ctl_model (
  input  wire logic  aclk,
  input  wire logic  rx_ready,
  output logic       ren_n,
  output logic       ifc_n,
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       rx_atn_n,
  output logic       rx_eoi_n,
  output logic       tx_ready
);
  // idle bus: lines released, handshake lines low
  initial begin
    ren_n = 1'b1;
    ifc_n = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_atn_n = 1'b1;
    rx_eoi_n = 1'b1;
    tx_ready = 1'b0;
  end
  // listener side accepts at random, so talker bytes may stall
  always @(posedge aclk) tx_ready <= 1'($urandom % 2);
  // one byte; command bytes go with attention low, data waits for ready
  task automatic send(input logic atn_n, input logic [7:0] b);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_data <= b;
    rx_atn_n <= atn_n;
    do @(posedge aclk); while (atn_n && !rx_ready);
    rx_valid <= 1'b0;
    rx_data <= ~b; // released lines never show the stale byte
    rx_atn_n <= 1'b1;
  endtask
  // uniline remote enable and interface clear
  task automatic lines(input logic ren, input logic ifc);
    @(posedge aclk);
    ren_n <= ren;
    ifc_n <= ifc;
  endtask
endmodule

/* File: dv/test_gpib_remote_status_logic.sv */
// testbench: remote/local, addressed commands, status byte, serial poll
`timescale 1ns/1ps
module test_gpib_remote_status_logic;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, local_key = 0, remote_key = 0;
  logic [7:0]  awaddr = 0, araddr = 0, keypad_in = 0, std_evt = 0;
  logic [31:0] wdata = 0, cond = 0;
  logic        awready, wready, bvalid, arready, rvalid, rx_ready, tx_valid;
  logic        tx_eoi, srq_out, srq_oe_n, remote_led, trigger;
  logic        ren_n, ifc_n, rx_valid, rx_atn_n, rx_eoi_n, tx_ready;
  logic [1:0]  bresp, rresp;
  logic [7:0]  rx_data, tx_data, keypad_out;
  logic [31:0] rdata;
  logic [33:0] exp_q[$];
  int          fails = 0, checks_done = 0, trig_cnt = 0;
  grsl_top grsl_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ren_n(ren_n), .ifc_n(ifc_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_atn_n(rx_atn_n), .rx_eoi_n(rx_eoi_n), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_eoi(tx_eoi),
    .tx_ready(tx_ready), .srq_out(srq_out), .srq_oe_n(srq_oe_n),
    .local_key(local_key), .remote_key(remote_key), .keypad_in(keypad_in),
    .keypad_out(keypad_out), .remote_led(remote_led), .trigger(trigger),
    .cond(cond), .std_evt(std_evt));
  grsl_ctl_model grsl_ctl_model_i (.aclk(aclk), .rx_ready(rx_ready),
    .ren_n(ren_n), .ifc_n(ifc_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_atn_n(rx_atn_n), .rx_eoi_n(rx_eoi_n), .tx_ready(tx_ready));
  // 100 MHz clock
  initial forever #5 aclk = ~aclk;
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1;
    pw = 1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awready) begin awvalid <= 0; pa = 0; end
      if (pw && wready) begin wvalid <= 0; pw = 0; end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 0;
    chk(34'(bresp), 34'(grsl_pkg::RESP_OKAY));
  endtask
  // read: expected {resp, data} noted before the request goes out
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
  endtask
  // watcher: each read answer or talker byte takes the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
    else if (tx_valid && tx_ready)
      chk(34'({tx_eoi, tx_data}), exp_q.pop_front());
    if (trigger) trig_cnt++;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    test_done();
  end
  initial begin
    void'($urandom(26));
    cond[31:8] <= 24'($urandom);
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(grsl_pkg::OFF_CTRL, 34'h0c);
    rd(grsl_pkg::OFF_STB, 34'h0);
    rd(8'hfc, {grsl_pkg::RESP_SLVERR, 32'h0});
    keypad_in <= 8'($urandom);
    repeat (2) @(posedge aclk);
    chk(34'(keypad_out), 34'(keypad_in));
    grsl_ctl_model_i.lines(1'b0, 1'b1);
    repeat (3) @(posedge aclk);
    chk(34'({remote_led, keypad_out}), 34'h100);
    local_key <= 1;
    @(posedge aclk) local_key <= 0;
    repeat (2) @(posedge aclk);
    chk(34'(remote_led), 34'h0);
    remote_key <= 1;
    @(posedge aclk) remote_key <= 0;
    grsl_ctl_model_i.send(1'b0, grsl_pkg::CMD_LLO);
    local_key <= 1;
    @(posedge aclk) local_key <= 0;
    repeat (2) @(posedge aclk);
    chk(34'(remote_led), 34'h1);
    grsl_ctl_model_i.send(1'b0, grsl_pkg::CMD_GET);
    grsl_ctl_model_i.send(1'b0, 8'h2c);
    grsl_ctl_model_i.send(1'b0, grsl_pkg::CMD_GET);
    repeat (3) @(posedge aclk);
    chk(34'(trig_cnt), 34'h1);
    grsl_ctl_model_i.send(1'b0, grsl_pkg::CMD_GTL);
    repeat (2) @(posedge aclk);
    chk(34'(remote_led), 34'h0);
    // a pending response is held while not talking, then a query drops it
    wr(grsl_pkg::OFF_RSP, 32'h1a5);
    grsl_ctl_model_i.send(1'b1, grsl_pkg::CH_QMARK);
    rd(grsl_pkg::OFF_RXD, 34'h3f);
    grsl_ctl_model_i.send(1'b1, grsl_pkg::CH_LF);
    rd(grsl_pkg::OFF_RSP, 34'ha5);
    wr(grsl_pkg::OFF_SET_BASE + grsl_pkg::SET_ENA, 32'h1);
    wr(grsl_pkg::OFF_SRE, 32'h1);
    cond[7:0] <= 8'h01;
    repeat (4) @(posedge aclk);
    chk(34'({srq_out, srq_oe_n}), 34'h0);
    rd(grsl_pkg::OFF_SET_BASE, 34'h1);
    rd(grsl_pkg::OFF_STB, 34'h41);
    exp_q.push_back(34'h41);
    grsl_ctl_model_i.send(1'b0, grsl_pkg::CMD_SPE);
    grsl_ctl_model_i.send(1'b0, 8'h4c);
    while (exp_q.size() != 0) @(posedge aclk);
    grsl_ctl_model_i.send(1'b0, grsl_pkg::CMD_SPD);
    exp_q.push_back(34'h155);
    wr(grsl_pkg::OFF_RSP, 32'h155);
    while (exp_q.size() != 0) @(posedge aclk);
    rd(grsl_pkg::OFF_SET_BASE + grsl_pkg::SET_EVT, 34'h1);
    rd(grsl_pkg::OFF_STB, 34'h0);
    chk(34'(srq_oe_n), 34'h1);
    wr(grsl_pkg::OFF_SET_BASE + grsl_pkg::SET_ENA, 32'h0);
    rd(grsl_pkg::OFF_SET_BASE + grsl_pkg::SET_ENA, 34'h0);
    // interface clear drops talk address, device clear drops the response
    grsl_ctl_model_i.lines(1'b0, 1'b0);
    grsl_ctl_model_i.lines(1'b0, 1'b1);
    wr(grsl_pkg::OFF_RSP, 32'h77);
    rd(grsl_pkg::OFF_RSP, 34'h177);
    grsl_ctl_model_i.send(1'b0, grsl_pkg::CMD_DCL);
    rd(grsl_pkg::OFF_RSP, 34'h77);
    std_evt <= 8'h20;
    @(posedge aclk) std_evt <= 8'h00;
    rd(grsl_pkg::OFF_ESR, 34'h20);
    rd(grsl_pkg::OFF_ESR, 34'h0);
    repeat (2) @(posedge aclk);
    test_done();
  end
endmodule
